// file: logic/gsled_top.sv
// Gateway status indicator driver: six front-panel LEDs from device state
//
// How it works
// R1: Run LED: off INIT, on OP, blink PREOP, single flash SAFEOP.
// R2: Error LED off when no error condition is present.
// R3: Error LED steady red on application watchdog timeout.
// R4: Error LED blinks red on general configuration error.
// R5: Error LED single red flash when state change field equals 01.
// R6: Error LED red double flash on sync manager watchdog timeout.
// R7: Port 1 LED off no link, green with link, flicker on traffic.
// R8: Port 2 LED off no link, green with link, flicker on traffic.
// R9: Subnet LED off unpowered, green running, flashing green after transaction errors.
// R10: Subnet LED steady red on error or stopped subnet.
// R11: Device LED off, alternating red/green bad config, green init, flashing running.
// R12: Device LED steady red in bootloader mode.
// R13: Device fault shows a flash sequence opening with red flashes.
// R14: All patterns come from one prescaled timebase with durations set in ticks.
`timescale 1ns/1ps
`default_nettype none
module gsled_top
  import gsled_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire gsled_bus_stat_t bus_stat,
  input wire gsled_port_t port1,
  input wire gsled_port_t port2,
  input wire gsled_sub_t sub_stat,
  input wire gsled_dev_t dev_stat,
  output gsled_led_t run_led,
  output gsled_led_t err_led,
  output gsled_led_t link1_led,
  output gsled_led_t link2_led,
  output gsled_led_t sub_led,
  output gsled_led_t dev_led
);

  logic tick;
  gsled_phase_t phase;
  gsled_led_t fault_led;
  gsled_pat_t run_pat;
  gsled_pat_t err_pat;
  gsled_led_t run_d;
  gsled_led_t err_d;
  gsled_led_t link1_d;
  gsled_led_t link2_d;
  gsled_led_t sub_d;
  gsled_led_t dev_d;

  // Evaluates one pattern against the shared phases
  function automatic logic pat_on(input gsled_pat_t p, input gsled_phase_t ph);
    logic on;
    on = 1'b0;
    unique case (p)
      GSLED_PAT_OFF: on = 1'b0;
      GSLED_PAT_ON: on = 1'b1;
      GSLED_PAT_BLINK: on = ph.blink;
      GSLED_PAT_SINGLE: on = ph.single;
      GSLED_PAT_DOUBLE: on = ph.dbl;
      GSLED_PAT_FLICKER: on = ph.flicker;
      default: on = 1'b0;
    endcase
    return on;
  endfunction

  // Link indicator: steady with link, flicker while traffic
  function automatic gsled_led_t link_led(input gsled_port_t p, input gsled_phase_t ph);
    gsled_led_t l;
    l.red = 1'b0;
    l.green = p.link && (p.activity ? ph.flicker : 1'b1);
    return l;
  endfunction

  // ==========================================================================
  // Shared timebase and fault sequencer
  // ==========================================================================
  gsled_timebase #(
    .TICK_DIV(TICK_DIV)
  ) u_timebase (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .phase(phase) // R14
  );

  gsled_fault_seq u_fault_seq (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .enable(dev_stat.powered && dev_stat.fault),
    .code(dev_stat.fault_code),
    .led(fault_led) // R13
  );

  // ==========================================================================
  // Run indicator
  // ==========================================================================
  always_comb begin
    unique case (bus_stat.app_layer_state)
      APP_OP: run_pat = GSLED_PAT_ON; // R1
      APP_PREOP: run_pat = GSLED_PAT_BLINK; // R1
      APP_SAFEOP: run_pat = GSLED_PAT_SINGLE; // R1
      default: run_pat = GSLED_PAT_OFF; // R1
    endcase
    run_d.red = 1'b0;
    run_d.green = pat_on(run_pat, phase);
  end

  // ==========================================================================
  // Error indicator, most severe condition first
  // ==========================================================================
  always_comb begin
    if (bus_stat.app_wdog_timeout) begin
      err_pat = GSLED_PAT_ON; // R3
    end else if (bus_stat.sm_wdog_timeout) begin
      err_pat = GSLED_PAT_DOUBLE; // R6
    end else if (bus_stat.config_error) begin
      err_pat = GSLED_PAT_BLINK; // R4
    end else if (bus_stat.app_layer_change == CHANGE_AUTONOMOUS) begin
      err_pat = GSLED_PAT_SINGLE; // R5
    end else begin
      err_pat = GSLED_PAT_OFF; // R2
    end
    err_d.green = 1'b0;
    err_d.red = pat_on(err_pat, phase);
  end

  // ==========================================================================
  // Link, subnetwork and device indicators
  // ==========================================================================
  assign link1_d = link_led(port1, phase); // R7
  assign link2_d = link_led(port2, phase); // R8

  always_comb begin
    sub_d = '0;
    if (!sub_stat.powered) begin
      sub_d = '0; // R9
    end else if (sub_stat.error_now || sub_stat.stopped) begin
      sub_d.red = 1'b1; // R10
    end else if (sub_stat.running && sub_stat.had_errors) begin
      sub_d.green = phase.blink; // R9
    end else if (sub_stat.running) begin
      sub_d.green = 1'b1; // R9
    end
  end

  always_comb begin
    dev_d = '0;
    if (!dev_stat.powered) begin
      dev_d = '0; // R11
    end else if (dev_stat.fault) begin
      dev_d = fault_led; // R13
    end else if (dev_stat.bootloader) begin
      dev_d.red = 1'b1; // R12
    end else if (dev_stat.config_bad) begin
      dev_d.red = phase.alt; // R11
      dev_d.green = ~phase.alt; // R11
    end else if (dev_stat.initializing) begin
      dev_d.green = 1'b1; // R11
    end else if (dev_stat.running) begin
      dev_d.green = phase.blink; // R11
    end
  end

  // ==========================================================================
  // Output registers
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_led <= '0;
      err_led <= '0;
      link1_led <= '0;
      link2_led <= '0;
      sub_led <= '0;
      dev_led <= '0;
    end else begin
      run_led <= run_d;
      err_led <= err_d;
      link1_led <= link1_d;
      link2_led <= link2_d;
      sub_led <= sub_d;
      dev_led <= dev_d;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_op_state;
    bus_stat.app_layer_state == APP_OP;
  endsequence

  a_run_off_init: assert property (@(posedge clk) disable iff (rst)
    (bus_stat.app_layer_state == APP_INIT) |=> !run_led.green) // R1
    else $error("run led lit in init");
  a_run_on_op: assert property (@(posedge clk) disable iff (rst)
    s_op_state |=> run_led.green && !run_led.red) // R1
    else $error("run led not steady in operational");
  a_err_idle_off: assert property (@(posedge clk) disable iff (rst)
    (bus_stat == {bus_stat.app_layer_state, 5'h00}) |=> !err_led.red) // R2
    else $error("error led lit without error");
  a_err_app_wdog: assert property (@(posedge clk) disable iff (rst)
    bus_stat.app_wdog_timeout |=> err_led.red) // R3
    else $error("error led not red on watchdog");
  a_err_never_grn: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> !err_led.green) // R4
    else $error("error led shows green");
  a_err_cfg_blink: assert property (@(posedge clk) disable iff (rst) // R4
    bus_stat.config_error && !bus_stat.app_wdog_timeout && !bus_stat.sm_wdog_timeout
    |=> err_led.red == $past(phase.blink))
    else $error("error led not blinking on configuration error");
  a_err_sm_dbl: assert property (@(posedge clk) disable iff (rst) // R6
    bus_stat.sm_wdog_timeout && !bus_stat.app_wdog_timeout |=> err_led.red == $past(phase.dbl))
    else $error("error led not double flashing on sync watchdog");
  a_link1_nolink: assert property (@(posedge clk) disable iff (rst)
    !port1.link |=> link1_led == '0) // R7
    else $error("port 1 led lit without link");
  a_link2_steady: assert property (@(posedge clk) disable iff (rst)
    port2.link && !port2.activity |=> link2_led.green) // R8
    else $error("port 2 led not steady with link");
  a_sub_red_err: assert property (@(posedge clk) disable iff (rst)
    sub_stat.powered && sub_stat.stopped |=> sub_led.red && !sub_led.green) // R10
    else $error("subnet led not red when stopped");
  a_dev_boot_red: assert property (@(posedge clk) disable iff (rst)
    dev_stat.powered && !dev_stat.fault && dev_stat.bootloader |=> dev_led.red) // R12
    else $error("device led not red in bootloader");
  a_dev_alt_both: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> !(dev_led.red && dev_led.green)) // R11
    else $error("device led shows both colours");
  a_dev_fault_red: assert property (@(posedge clk) disable iff (rst)
    $rose(dev_stat.powered && dev_stat.fault) |=> ##[1:3] dev_led.red) // R13
    else $error("fault sequence did not open red");

endmodule
`default_nettype wire

// file: include/gsled_pkg.sv
// Package for the gateway status indicator driver: types, encodings and timing constants
package gsled_pkg;

  // ==========================================================================
  // Clock and timebase
  // ==========================================================================
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_CNT_W = 18;

  // Pattern durations in timebase ticks (1 ms each)
  localparam int unsigned BLINK_TICKS = 200;
  localparam int unsigned FLASH_ON_TICKS = 200;
  localparam int unsigned FLASH_GAP_TICKS = 200;
  localparam int unsigned FLASH_OFF_TICKS = 1000;
  localparam int unsigned FLICKER_TICKS = 50;
  localparam int unsigned FAULT_FLASH_TICKS = 300;
  localparam int unsigned FAULT_GAP_TICKS = 1500;
  localparam int unsigned PAT_CNT_W = 11;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  localparam logic [3:0] APP_INIT = 4'h1;
  localparam logic [3:0] APP_PREOP = 4'h2;
  localparam logic [3:0] APP_SAFEOP = 4'h4;
  localparam logic [3:0] APP_OP = 4'h8;
  localparam logic [1:0] CHANGE_AUTONOMOUS = 2'h1;
  localparam int unsigned FAULT_CODE_W = 4;

  typedef enum logic [2:0] {
    GSLED_PAT_OFF,
    GSLED_PAT_ON,
    GSLED_PAT_BLINK,
    GSLED_PAT_SINGLE,
    GSLED_PAT_DOUBLE,
    GSLED_PAT_FLICKER
  } gsled_pat_t;

  // Colour drive of one bicolour indicator
  typedef struct packed {
    logic red;
    logic green;
  } gsled_led_t;

  typedef struct packed {
    logic [3:0] app_layer_state;
    logic [1:0] app_layer_change;
    logic app_wdog_timeout;
    logic config_error;
    logic sm_wdog_timeout;
  } gsled_bus_stat_t;

  typedef struct packed {
    logic link;
    logic activity;
  } gsled_port_t;

  typedef struct packed {
    logic powered;
    logic running;
    logic had_errors;
    logic error_now;
    logic stopped;
  } gsled_sub_t;

  typedef struct packed {
    logic powered;
    logic config_bad;
    logic initializing;
    logic running;
    logic bootloader;
    logic fault;
    logic [FAULT_CODE_W-1:0] fault_code;
  } gsled_dev_t;

  typedef struct packed {
    logic blink;
    logic single;
    logic dbl;
    logic flicker;
    logic alt;
  } gsled_phase_t;

endpackage

// file: logic/gsled_timebase.sv
// Shared prescaled timebase and the common blink, flash and flicker phases
`timescale 1ns/1ps
`default_nettype none
module gsled_timebase
  import gsled_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick,
  output gsled_phase_t phase
);

  logic [TICK_CNT_W-1:0] pre_q;
  logic [PAT_CNT_W-1:0] blink_q;
  logic [PAT_CNT_W-1:0] flash_q;
  logic [PAT_CNT_W-1:0] flick_q;
  logic blink_ph_q;
  logic flick_ph_q;

  // ==========================================================================
  // Prescaler
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      tick <= 1'b0;
    end else if (pre_q == TICK_CNT_W'(TICK_DIV - 1)) begin
      pre_q <= '0;
      tick <= 1'b1;
    end else begin
      pre_q <= pre_q + 1'b1;
      tick <= 1'b0;
    end
  end

  // ==========================================================================
  // Pattern counters
  // ==========================================================================
  localparam int unsigned FLASH_PERIOD = 3 * FLASH_ON_TICKS + FLASH_GAP_TICKS + FLASH_OFF_TICKS;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_q <= '0;
      blink_ph_q <= 1'b0;
    end else if (tick) begin
      if (blink_q == PAT_CNT_W'(BLINK_TICKS - 1)) begin
        blink_q <= '0;
        blink_ph_q <= ~blink_ph_q;
      end else begin
        blink_q <= blink_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flick_q <= '0;
      flick_ph_q <= 1'b0;
    end else if (tick) begin
      if (flick_q == PAT_CNT_W'(FLICKER_TICKS - 1)) begin
        flick_q <= '0;
        flick_ph_q <= ~flick_ph_q;
      end else begin
        flick_q <= flick_q + 1'b1;
      end
    end
  end

  // Single flash: on, long off.  Double flash: on, gap, on, long off.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_q <= '0;
    end else if (tick) begin
      flash_q <= (flash_q == PAT_CNT_W'(FLASH_PERIOD - 1)) ? '0 : flash_q + 1'b1;
    end
  end

  // One process builds the whole phase bundle; alternation follows the blink phase
  always_comb begin
    phase.blink = blink_ph_q;
    phase.alt = blink_ph_q;
    phase.flicker = flick_ph_q;
    phase.single = (flash_q < PAT_CNT_W'(FLASH_ON_TICKS));
    phase.dbl = phase.single ||
                ((flash_q >= PAT_CNT_W'(FLASH_ON_TICKS + FLASH_GAP_TICKS)) &&
                 (flash_q < PAT_CNT_W'(2 * FLASH_ON_TICKS + FLASH_GAP_TICKS)));
  end

endmodule
`default_nettype wire

// file: logic/gsled_fault_seq.sv
// Fault code flash sequence: a number of red flashes followed by one green flash
`timescale 1ns/1ps
`default_nettype none
module gsled_fault_seq
  import gsled_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic [FAULT_CODE_W-1:0] code,
  output gsled_led_t led
);

  typedef enum {
    GSLED_FS_IDLE,
    GSLED_FS_RED_ON,
    GSLED_FS_RED_OFF,
    GSLED_FS_GRN_ON,
    GSLED_FS_PAUSE
  } gsled_fs_t;

  gsled_fs_t st_q;
  logic [PAT_CNT_W-1:0] cnt_q;
  logic [FAULT_CODE_W-1:0] left_q;
  logic [FAULT_CODE_W-1:0] flashes;

  // At least one red flash always opens the sequence
  assign flashes = (code == '0) ? FAULT_CODE_W'(1) : code;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= GSLED_FS_IDLE;
      cnt_q <= '0;
      left_q <= '0;
    end else if (!enable) begin
      st_q <= GSLED_FS_IDLE;
      cnt_q <= '0;
    end else if (st_q == GSLED_FS_IDLE) begin
      st_q <= GSLED_FS_RED_ON;
      left_q <= flashes;
      // The opening red flash lasts the full flash time like every other one
      cnt_q <= PAT_CNT_W'(FAULT_FLASH_TICKS - 1);
    end else if (tick) begin
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end else begin
        unique case (st_q)
          GSLED_FS_RED_ON: begin
            st_q <= GSLED_FS_RED_OFF;
            left_q <= left_q - 1'b1;
            cnt_q <= PAT_CNT_W'(FAULT_FLASH_TICKS - 1);
          end
          GSLED_FS_RED_OFF: begin
            st_q <= (left_q == '0) ? GSLED_FS_GRN_ON : GSLED_FS_RED_ON;
            cnt_q <= PAT_CNT_W'(FAULT_FLASH_TICKS - 1);
          end
          GSLED_FS_GRN_ON: begin
            st_q <= GSLED_FS_PAUSE;
            cnt_q <= PAT_CNT_W'(FAULT_GAP_TICKS - 1);
          end
          GSLED_FS_PAUSE: begin
            st_q <= GSLED_FS_RED_ON;
            left_q <= flashes;
            cnt_q <= PAT_CNT_W'(FAULT_FLASH_TICKS - 1);
          end
          GSLED_FS_IDLE: begin
            st_q <= GSLED_FS_RED_ON;
          end
        endcase
      end
    end
  end

  always_comb begin
    led.red = (st_q == GSLED_FS_RED_ON);
    led.green = (st_q == GSLED_FS_GRN_ON);
  end

endmodule
`default_nettype wire

// file: dv/gsled_panel.sv
// Operator view of the front-panel indicators: lit time and flash counts of one LED
`timescale 1ns/1ps
`default_nettype none
module gsled_panel
  import gsled_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [2:0] sel,
  input wire gsled_led_t [5:0] leds,
  output logic [15:0] g_on,
  output logic [15:0] r_on,
  output logic [15:0] g_rise,
  output logic [15:0] r_rise
);
  gsled_led_t cur;
  gsled_led_t prev_q;

  assign cur = leds[sel];

  // Counts restart on clear; the LED state seen at clear is the base for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      g_on <= 16'h0;
      r_on <= 16'h0;
      g_rise <= 16'h0;
      r_rise <= 16'h0;
      prev_q <= '0;
    end else if (clear) begin
      g_on <= 16'h0;
      r_on <= 16'h0;
      g_rise <= 16'h0;
      r_rise <= 16'h0;
      prev_q <= cur;
    end else begin
      g_on <= g_on + {15'h0, cur.green};
      r_on <= r_on + {15'h0, cur.red};
      g_rise <= g_rise + {15'h0, cur.green & ~prev_q.green};
      r_rise <= r_rise + {15'h0, cur.red & ~prev_q.red};
      prev_q <= cur;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the gateway status indicator driver
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import gsled_pkg::*;
;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  localparam int unsigned DIV = 4;
  localparam int BL = 3200;
  localparam int FL = 7200;
  localparam int LIMIT = 90000;
  logic clk;
  logic rst;
  logic clear;
  logic [2:0] sel;
  gsled_bus_stat_t bus_stat;
  gsled_port_t port1;
  gsled_port_t port2;
  gsled_sub_t sub_stat;
  gsled_dev_t dev_stat;
  gsled_led_t run_led;
  gsled_led_t err_led;
  gsled_led_t link1_led;
  gsled_led_t link2_led;
  gsled_led_t sub_led;
  gsled_led_t dev_led;
  logic [15:0] g_on;
  logic [15:0] r_on;
  logic [15:0] g_rise;
  logic [15:0] r_rise;
  logic [11:0] all_leds;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  assign all_leds = {run_led, err_led, link1_led, link2_led, sub_led, dev_led};

  gsled_top #(.TICK_DIV(DIV)) gsled_top_i (
    .clk(clk),
    .rst(rst),
    .bus_stat(bus_stat),
    .port1(port1),
    .port2(port2),
    .sub_stat(sub_stat),
    .dev_stat(dev_stat),
    .run_led(run_led),
    .err_led(err_led),
    .link1_led(link1_led),
    .link2_led(link2_led),
    .sub_led(sub_led),
    .dev_led(dev_led)
  );

  gsled_panel gsled_panel_i (
    .clk(clk),
    .rst(rst),
    .clear(clear),
    .sel(sel),
    .leds({dev_led, sub_led, link2_led, link1_led, err_led, run_led}),
    .g_on(g_on),
    .r_on(r_on),
    .g_rise(g_rise),
    .r_rise(r_rise)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      n_errors++;
      $display("Timeout after %0d cycles", cycles);
      final_report();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Settle, then count n samples of LED idx and compare lit time and edges
  task automatic measure(string what, int idx, int n, int eg, int er, int gr, int rr);
    sel = 3'(idx);
    repeat (4) step();
    clear = 1'b1;
    step();
    clear = 1'b0;
    repeat (n) step();
    check({what, " green time"}, 16'(eg), g_on);
    check({what, " red time"}, 16'(er), r_on);
    check({what, " green edges"}, 16'(gr), g_rise);
    check({what, " red edges"}, 16'(rr), r_rise);
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    repeat (8) step();
    check("leds in reset", 16'h0, {4'h0, all_leds});
    rst = 1'b0;
    step();
    check("leds after reset", 16'h0, {4'h0, all_leds});
  endtask

  task automatic t_run();
    bus_stat.app_layer_state = APP_INIT;
    measure("run init", 0, 64, 0, 0, 0, 0);
    bus_stat.app_layer_state = APP_OP;
    measure("run op", 0, 64, 64, 0, 0, 0);
    bus_stat.app_layer_state = APP_PREOP;
    measure("run preop", 0, BL, 1600, 0, 2, 0);
    bus_stat.app_layer_state = APP_SAFEOP;
    measure("run safeop", 0, FL, 800, 0, 1, 0);
    bus_stat.app_layer_state = 4'h3;
    measure("run bad code", 0, 64, 0, 0, 0, 0);
  endtask

  task automatic t_err();
    bus_stat = '0;
    bus_stat.app_layer_change = 2'h2;
    measure("err none", 1, 64, 0, 0, 0, 0);
    bus_stat.config_error = 1'b1;
    measure("err config", 1, BL, 0, 1600, 0, 2);
    bus_stat.config_error = 1'b0;
    bus_stat.app_layer_change = CHANGE_AUTONOMOUS;
    measure("err change", 1, FL, 0, 800, 0, 1);
    bus_stat.sm_wdog_timeout = 1'b1;
    measure("err sm wdog", 1, FL, 0, 1600, 0, 2);
    bus_stat.app_wdog_timeout = 1'b1;
    measure("err app wdog", 1, 64, 0, 64, 0, 0);
    bus_stat = '0;
  endtask

  task automatic t_link();
    gsled_port_t p;
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 2'h1 : ((i == 1) ? 2'h2 : 2'h3);
      port1 = p;
      port2 = '0;
      measure("link1", 2, BL, (i == 0) ? 0 : ((i == 1) ? BL : 1600), 0, (i == 2) ? 8 : 0, 0);
      port2 = p;
      port1 = '0;
      measure("link2", 3, BL, (i == 0) ? 0 : ((i == 1) ? BL : 1600), 0, (i == 2) ? 8 : 0, 0);
    end
  endtask

  task automatic t_sub();
    sub_stat = '0;
    sub_stat.running = 1'b1;
    measure("sub unpowered", 4, 64, 0, 0, 0, 0);
    sub_stat.powered = 1'b1;
    measure("sub running", 4, 64, 64, 0, 0, 0);
    sub_stat.had_errors = 1'b1;
    measure("sub had errors", 4, BL, 1600, 0, 2, 0);
    sub_stat.error_now = 1'b1;
    measure("sub error", 4, 64, 0, 64, 0, 0);
    sub_stat.error_now = 1'b0;
    sub_stat.stopped = 1'b1;
    measure("sub stopped", 4, 64, 0, 64, 0, 0);
  endtask

  task automatic t_dev();
    dev_stat = '0;
    dev_stat.running = 1'b1;
    measure("dev unpowered", 5, 64, 0, 0, 0, 0);
    dev_stat.powered = 1'b1;
    measure("dev running", 5, BL, 1600, 0, 2, 0);
    dev_stat.initializing = 1'b1;
    measure("dev init", 5, 64, 64, 0, 0, 0);
    dev_stat.config_bad = 1'b1;
    measure("dev config", 5, BL, 1600, 1600, 2, 2);
    dev_stat.bootloader = 1'b1;
    measure("dev boot", 5, 64, 0, 64, 0, 0);
    dev_stat.powered = 1'b0;
    measure("dev off", 5, 64, 0, 0, 0, 0);
  endtask

  // From a dark LED, a fault of code 2 outranks the bootloader state
  task automatic t_fault();
    dev_stat.powered = 1'b1;
    dev_stat.fault = 1'b1;
    dev_stat.fault_code = 4'h2;
    clear = 1'b1;
    step();
    clear = 1'b0;
    repeat (4) step();
    check("fault first red", 16'h2, {14'h0, dev_led});
    repeat (9995) step();
    check("fault red flashes", 16'h2, r_rise);
    check("fault green flashes", 16'h1, g_rise);
  endtask

  // Code 0 still opens with one red flash, then one green flash
  task automatic t_fault_zero();
    dev_stat.fault = 1'b0;
    step();
    dev_stat.fault = 1'b1;
    dev_stat.fault_code = 4'h0;
    clear = 1'b1;
    step();
    clear = 1'b0;
    repeat (7000) step();
    check("fault zero red flashes", 16'h1, r_rise);
    check("fault zero green flashes", 16'h1, g_rise);
  endtask

  initial begin
    rst = 1'b1;
    clear = 1'b0;
    sel = 3'h5;
    bus_stat = '0;
    port1 = '0;
    port2 = '0;
    sub_stat = '0;
    dev_stat = '0;
    t_reset();
    t_run();
    t_err();
    t_link();
    t_sub();
    t_dev();
    t_fault();
    t_fault_zero();
    final_report();
  end
endmodule
`default_nettype wire
